/* File: phy_digital_tx_config_regs.sv */
// digital configuration and transmit control registers behind APB.
// assumes an APB master on MCLK; strap pins are asynchronous levels,
// receive error sources come from logic on MCLK.
`timescale 1ns/1ns
`include "phy_cfg_params.svh"

module phy_digital_tx_config_regs (
    input wire logic MCLK, // 50 MHz clock
    input wire logic RST_B, // async reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [9:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error
    input wire logic [1:0] EDGE_RATE_STRAP_PINS, // rise-time straps
    input wire logic RX_ERR_NORMAL, // normal receive error
    input wire logic RX_SYM_ERR, // 100BASE-X symbol error
    output logic MII_RXER, // receive error toward the MAC
    output logic MII_DRIVE_HIGH, // raised MII output drive
    output logic TX_LOW_POWER, // transmitter low-power mode
    output logic TX_ZERO_DIFF, // zero-differential line state
    output phy_cfg_pkg::rise_t TX_RISE_SEL // rise-time select
);
    import phy_cfg_pkg::*;

    logic [15:0] digcfg_reg;
    logic [15:0] digcfg_next;
    logic [15:0] txctl_reg;
    logic [15:0] txctl_next;
    logic [31:0] prdata_reg;
    logic [1:0] strap_sync;
    logic [1:0] strap_pend_reg;
    logic strap_load;
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic rd_setup;
    regsel_t sel;
    logic rxer_reg;
    logic drive_reg;
    logic lowpwr_reg;
    rise_t rise_reg;

    // byte address to register select
    function automatic regsel_t decode(input logic [9:0] addr);
        regsel_t s;
        s = SEL_NONE;
        if (addr == `DIGCFG_ADDR) begin
            s = SEL_DIGCFG;
        end else if (addr == `TXCTL_ADDR) begin
            s = SEL_TXCTL;
        end
        return s;
    endfunction

    // merge write data under byte strobes and the writable mask
    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [15:0] wmask
    );
        logic [15:0] lanes;
        logic [15:0] m;
        lanes = {{8{strb[1]}}, {8{strb[0]}}};
        m = lanes & wmask;
        return (old & ~m) | (wdata[15:0] & m);
    endfunction

    assign sel = decode(PADDR);
    assign setup_phase = PSEL && !PENABLE;
    assign access_phase = PSEL && PENABLE;
    assign wr_access = access_phase && PWRITE;
    assign rd_setup = setup_phase && !PWRITE;

    // zero wait states; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = access_phase && (sel == SEL_NONE);
    assign PRDATA = prdata_reg;

    bit_sync #(
        .WIDTH(2)
    ) u_strap_sync (
        .clk(MCLK),
        .rst_b(RST_B),
        .din(EDGE_RATE_STRAP_PINS),
        .dout(strap_sync)
    );

    // wait for the synchroniser to hold a real pin level, then load once
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_pend_reg <= `STRAP_WAIT;
        end else if (strap_pend_reg != 2'h0) begin
            strap_pend_reg <= strap_pend_reg - 2'h1;
        end
    end

    assign strap_load = (strap_pend_reg == 2'h1);

    // digital configuration: only writable fields take write data
    always_comb begin
        digcfg_next = digcfg_reg;
        if (wr_access && sel == SEL_DIGCFG) begin
            digcfg_next = merge(digcfg_reg, PWDATA, PSTRB,
                `DIGCFG_WMASK);
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            digcfg_reg <= `DIGCFG_RESET;
        end else begin
            digcfg_reg <= digcfg_next;
        end
    end

    // transmit control: strap load owns the rise field in its cycle
    always_comb begin
        txctl_next = txctl_reg;
        if (wr_access && sel == SEL_TXCTL) begin
            txctl_next = merge(txctl_reg, PWDATA, PSTRB, `TXCTL_WMASK);
        end
        if (strap_load) begin
            txctl_next[`TXCTL_RISE_HI:`TXCTL_RISE_LO] = strap_sync;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            txctl_reg <= `TXCTL_RESET;
        end else begin
            txctl_reg <= txctl_next;
        end
    end

    // read data captured in the setup phase, held through access
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (sel)
                SEL_DIGCFG: begin
                    prdata_reg <= {16'h0000, digcfg_reg};
                end
                SEL_TXCTL: begin
                    prdata_reg <= {16'h0000, txctl_reg};
                end
                default: begin
                    prdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // control outputs from flip-flops
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= digcfg_next[`DIGCFG_DRIVE_BIT];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            lowpwr_reg <= 1'b0;
        end else begin
            lowpwr_reg <= txctl_next[`TXCTL_LOWPWR_BIT];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rise_reg <= RISE_3P0;
        end else begin
            rise_reg <= rise_t'(
                txctl_next[`TXCTL_RISE_HI:`TXCTL_RISE_LO]);
        end
    end

    // receive error source select
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rxer_reg <= 1'b0;
        end else if (digcfg_reg[`DIGCFG_SYMERR_BIT]) begin
            rxer_reg <= RX_SYM_ERR;
        end else begin
            rxer_reg <= RX_ERR_NORMAL;
        end
    end

    assign MII_DRIVE_HIGH = drive_reg;
    assign TX_LOW_POWER = lowpwr_reg;
    assign TX_ZERO_DIFF = lowpwr_reg;
    assign TX_RISE_SEL = rise_reg;
    assign MII_RXER = rxer_reg;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    drive_strength_a: assert property (
        (wr_access && sel == SEL_DIGCFG && PSTRB[1])
        |=> (MII_DRIVE_HIGH == $past(PWDATA[`DIGCFG_DRIVE_BIT]))
    ) else $error("drive strength does not follow write");

    rxer_select_a: assert property (
        RST_B |=> (MII_RXER == ($past(digcfg_reg[`DIGCFG_SYMERR_BIT])
            ? $past(RX_SYM_ERR) : $past(RX_ERR_NORMAL)))
    ) else $error("receive error source is wrong");

    low_power_a: assert property (
        (wr_access && sel == SEL_TXCTL && PSTRB[1] && !strap_load)
        |=> (TX_LOW_POWER == $past(PWDATA[`TXCTL_LOWPWR_BIT]))
            && (TX_ZERO_DIFF == TX_LOW_POWER)
    ) else $error("low power state does not follow write");

    rise_write_a: assert property (
        (wr_access && sel == SEL_TXCTL && PSTRB[1] && !strap_load)
        |=> (TX_RISE_SEL == rise_t'($past(PWDATA[11:10])))
            ##1 (TX_RISE_SEL == rise_t'(txctl_reg[11:10]))
    ) else $error("rise time select does not follow write");

    strap_load_a: assert property (
        strap_load |=> (txctl_reg[11:10] == $past(strap_sync))
            && (TX_RISE_SEL == rise_t'($past(strap_sync)))
            && (strap_pend_reg == 2'h0)
    ) else $error("rise time not loaded from straps");

    reserved_read_a: assert property (
        (rd_setup && sel == SEL_DIGCFG)
        |=> (PRDATA[8:6] == 3'b000) && (PRDATA[3] == 1'b0)
            && (PRDATA[31:16] == 16'h0000)
    ) else $error("read-only reserved bits read nonzero");

    reserved_write_a: assert property (
        (wr_access && sel == SEL_DIGCFG && PSTRB == 4'hf)
        |=> (digcfg_reg == ($past(PWDATA[15:0]) & `DIGCFG_WMASK))
    ) else $error("writable reserved fields not stored");

    txctl_gap_a: assert property (
        ##1 (txctl_reg[9:5] == 5'b00000) [*3]
    ) else $error("transmit control undefined bits nonzero");

    // drive, low-power and rise outputs move only on a write or the one-time strap load
    drive_hold_a: assert property (
        !(wr_access && sel == SEL_DIGCFG)
        |=> $stable(MII_DRIVE_HIGH)
    ) else $error("drive strength changed without a write");

    sym_err_write_a: assert property (
        (wr_access && sel == SEL_DIGCFG && PSTRB[1])
        |=> (digcfg_reg[`DIGCFG_SYMERR_BIT] == $past(PWDATA[9]))
    ) else $error("symbol error select not stored");

    lowpwr_hold_a: assert property (
        !(wr_access && sel == SEL_TXCTL)
        |=> $stable(TX_LOW_POWER) && $stable(TX_ZERO_DIFF)
    ) else $error("low power changed without a write");

    rise_hold_a: assert property (
        !(wr_access && sel == SEL_TXCTL) && !strap_load
        |=> $stable(TX_RISE_SEL)
    ) else $error("rise time changed without a write");

    txctl_read_a: assert property (
        (rd_setup && sel == SEL_TXCTL)
        |=> (PRDATA == {16'h0000, $past(txctl_reg)})
    ) else $error("transmit control read data wrong");

    digcfg_hold_a: assert property (
        !(wr_access && sel == SEL_DIGCFG)
        |=> $stable(digcfg_reg)
    ) else $error("digital configuration changed without a write");

    digcfg_read_a: assert property (
        (rd_setup && sel == SEL_DIGCFG)
        |=> (PRDATA == {16'h0000, $past(digcfg_reg)})
    ) else $error("digital configuration read data wrong");

    unmapped_read_a: assert property (
        (rd_setup && sel == SEL_NONE)
        |=> (PRDATA == 32'h0000_0000)
    ) else $error("unmapped read data nonzero");

    unmapped_write_a: assert property (
        (wr_access && sel == SEL_NONE && !strap_load)
        |=> $stable(digcfg_reg) && $stable(txctl_reg)
    ) else $error("unmapped write changed a register");

    strobe_keep_a: assert property (
        (wr_access && sel == SEL_TXCTL && !PSTRB[1] && !strap_load)
        |=> (txctl_reg[15:8] == $past(txctl_reg[15:8]))
    ) else $error("strobe-off byte changed");

endmodule

/* File: phy_cfg_params.svh */
// offsets, field positions, reset values and timing counts for the
// digital configuration and transmit control register bank.
// assumes inclusion by bare name from the package and the design files.
//
// Behaviour
// - drive-strength bit 0 keeps normal MII drive, 1 raises it; resets 0.
// - symbol-error-show bit 1 puts 100BASE-X symbol error on receive error.
// - transmit-low-power bit 1 forces low power and zero-differential output.
// - two-bit rise-time code picks about 3.0, 3.4, 3.9 or 4.4 ns.
// - rise-time field loads from the two edge-rate strap pins at reset.
// - reserved fields reset to zero; software writes zero, ignores reads.
`ifndef PHY_CFG_PARAMS_SVH
`define PHY_CFG_PARAMS_SVH

// register indices; byte address is four times the index
`define DIGCFG_INDEX 8'h1a
`define TXCTL_INDEX 8'h1e
`define DIGCFG_ADDR 10'h068
`define TXCTL_ADDR 10'h078

// digital configuration fields
`define DIGCFG_DRIVE_BIT 11
`define DIGCFG_SYMERR_BIT 9
`define DIGCFG_WMASK 16'hfe37
`define DIGCFG_RESET 16'h0000

// transmit control fields
`define TXCTL_LOWPWR_BIT 12
`define TXCTL_RISE_HI 11
`define TXCTL_RISE_LO 10
`define TXCTL_WMASK 16'hfc1f
`define TXCTL_RESET 16'h0000

// approximate rise times per code, in picoseconds
`define RISE_TIME_00_PS 3000
`define RISE_TIME_01_PS 3400
`define RISE_TIME_10_PS 3900
`define RISE_TIME_11_PS 4400

// edges after reset release before the strap level is loaded
`define STRAP_WAIT 2'h3

`endif

/* File: phy_cfg_pkg.sv */
// types shared by the register bank and its testbench.
// assumes phy_cfg_params.svh is on the include path.
`include "phy_cfg_params.svh"

package phy_cfg_pkg;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_DIGCFG = 2'b01,
        SEL_TXCTL = 2'b10
    } regsel_t;

    typedef enum logic [1:0] {
        RISE_3P0 = 2'b00,
        RISE_3P4 = 2'b01,
        RISE_3P9 = 2'b10,
        RISE_4P4 = 2'b11
    } rise_t;

endpackage

/* File: bit_sync.sv */
// two flip-flop synchroniser for a group of slow pin levels.
// assumes the inputs change rarely relative to the clock.
`timescale 1ns/1ns

module bit_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk, // sampling clock
    input wire logic rst_b, // async reset, active low
    input wire logic [WIDTH-1:0] din, // asynchronous levels
    output logic [WIDTH-1:0] dout // synchronised levels
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= din[i];
                    sync_reg <= meta_reg;
                end
            end
            assign dout[i] = sync_reg;
        end
    endgenerate

endmodule

/* File: mac_mii_rx_model.sv */
// receive side of a 10/100 MAC as seen on the MII receive error line.
// assumes MII_RXER is driven from the same rising clock edge.
`timescale 1ns/1ns

module mac_mii_rx_model (
    input wire logic clk, // mii receive clock
    input wire logic rst_b, // async reset, active low
    input wire logic rxer, // receive error from the phy
    output logic rxer_q, // last sampled receive error
    output logic [7:0] err_cnt // cycles with receive error seen
);
    // sample on the rising edge as a mac does
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxer_q <= 1'b0;
            err_cnt <= 8'h00;
        end else begin
            rxer_q <= rxer;
            err_cnt <= err_cnt + {7'h00, rxer};
        end
    end
endmodule

/* File: tb_top.sv */
// self-checking bench for the digital and transmit configuration registers.
// assumes the design's params header is on the include path.
`timescale 1ns/1ns
`include "phy_cfg_params.svh"

module tb_top;
    import phy_cfg_pkg::*;
    typedef struct {
        logic [9:0] a;
        logic [15:0] wd;
        logic [3:0] st;
        logic [15:0] rd;
        logic [3:0] o;
    } row_t;
    logic MCLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
    logic PWRITE = 1'b0, PSLVERR, PREADY, MII_RXER, MII_DRIVE_HIGH;
    logic TX_LOW_POWER, TX_ZERO_DIFF, RX_ERR_NORMAL = 1'b0, RX_SYM_ERR = 1'b0;
    logic [9:0] PADDR = 10'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [3:0] PSTRB = 4'h0;
    logic [1:0] EDGE_RATE_STRAP_PINS = 2'b10;
    rise_t TX_RISE_SEL;
    logic rxer_q, er;
    logic [7:0] err_cnt, c0;
    int err_total = 0, n_checks = 0;
    row_t rows [10];

    always #10 MCLK = ~MCLK;

    phy_digital_tx_config_regs phy_digital_tx_config_regs_inst (.MCLK(MCLK),
        .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR),
        .EDGE_RATE_STRAP_PINS(EDGE_RATE_STRAP_PINS),
        .RX_ERR_NORMAL(RX_ERR_NORMAL), .RX_SYM_ERR(RX_SYM_ERR),
        .MII_RXER(MII_RXER), .MII_DRIVE_HIGH(MII_DRIVE_HIGH),
        .TX_LOW_POWER(TX_LOW_POWER), .TX_ZERO_DIFF(TX_ZERO_DIFF),
        .TX_RISE_SEL(TX_RISE_SEL));
    mac_mii_rx_model mac_mii_rx_model_inst (.clk(MCLK), .rst_b(RST_B),
        .rxer(MII_RXER), .rxer_q(rxer_q), .err_cnt(err_cnt));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= s;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge MCLK);
            i++;
        end while (PREADY !== 1'b1 && i < 50);
        if (i >= 50) begin
            err_total++;
            print_verdict();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic do_reset(input logic [1:0] strap);
        @(posedge MCLK);
        RST_B <= 1'b0;
        EDGE_RATE_STRAP_PINS <= strap;
        repeat (6) @(posedge MCLK);
        RST_B <= 1'b1;
        repeat (5) @(posedge MCLK);
    endtask

    initial begin
        // o holds drive, low power, rise code
        rows = '{'{`DIGCFG_ADDR, 16'h0800, 4'h3, 16'h0800, 4'ha},
                 '{`DIGCFG_ADDR, 16'hffff, 4'hf, 16'hfe37, 4'ha},
                 '{`DIGCFG_ADDR, 16'h0000, 4'h3, 16'h0000, 4'h2},
                 '{`TXCTL_ADDR, 16'h1000, 4'h3, 16'h1000, 4'h4},
                 '{`TXCTL_ADDR, 16'h0400, 4'h3, 16'h0400, 4'h1},
                 '{`TXCTL_ADDR, 16'h0800, 4'h3, 16'h0800, 4'h2},
                 '{`TXCTL_ADDR, 16'h0c00, 4'h3, 16'h0c00, 4'h3},
                 '{`TXCTL_ADDR, 16'hffff, 4'h3, 16'hfc1f, 4'h7},
                 '{`TXCTL_ADDR, 16'h0000, 4'h1, 16'hfc00, 4'h7},
                 '{`TXCTL_ADDR, 16'h0000, 4'h3, 16'h0000, 4'h0}};
        do_reset(2'b10);
        check("rise", {30'h0, TX_RISE_SEL}, {30'h0, RISE_3P9});
        check("drive", {31'h0, MII_DRIVE_HIGH}, 32'h0);
        check("lowpwr", {31'h0, TX_LOW_POWER}, 32'h0);
        apb(1'b0, `DIGCFG_ADDR, 32'h0, 4'h0);
        check("digcfg", rd, 32'h0);
        apb(1'b0, `TXCTL_ADDR, 32'h0, 4'h0);
        check("txctl", rd, 32'h0800);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, {16'h0, rows[i].wd}, rows[i].st);
            apb(1'b0, rows[i].a, 32'h0, 4'h0);
            check("readback", rd, {16'h0, rows[i].rd});
            check("rd err", 32'(er), 32'h0);
            check("drive", 32'(MII_DRIVE_HIGH), 32'(rows[i].o[3]));
            check("lowpwr", 32'(TX_LOW_POWER), 32'(rows[i].o[2]));
            check("zdiff", 32'(TX_ZERO_DIFF), 32'(rows[i].o[2]));
            check("rise", 32'(TX_RISE_SEL), 32'(rows[i].o[1:0]));
        end
        apb(1'b1, 10'h3fc, 32'hffff, 4'hf);
        check("unmapped wr err", {31'h0, er}, 32'h1);
        apb(1'b0, 10'h3fc, 32'h0, 4'h0);
        check("unmapped rd", rd, 32'h0);
        check("unmapped rd err", {31'h0, er}, 32'h1);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `DIGCFG_ADDR, s[0] ? 32'h0200 : 32'h0, 4'h3);
            for (int k = 0; k < 2; k++) begin
                @(posedge MCLK);
                RX_ERR_NORMAL <= k[0];
                RX_SYM_ERR <= ~k[0];
                repeat (3) @(posedge MCLK);
                check("rxer", {31'h0, rxer_q}, {31'h0, s[0] ^ k[0]});
                @(negedge MCLK);
                c0 = err_cnt;
                repeat (4) @(negedge MCLK);
                check("rxcnt", {24'h0, err_cnt - c0},
                    {29'h0, s[0] ^ k[0], 2'b00});
            end
        end
        apb(1'b1, `DIGCFG_ADDR, 32'h3800, 4'h3);
        apb(1'b0, `DIGCFG_ADDR, 32'h0, 4'h0);
        check("digcfg rsvd", rd, 32'h3800);
        do_reset(2'b01);
        apb(1'b0, `DIGCFG_ADDR, 32'h0, 4'h0);
        check("digcfg", rd, 32'h0);
        apb(1'b0, `TXCTL_ADDR, 32'h0, 4'h0);
        check("txctl", rd, 32'h0400);
        check("rise", {30'h0, TX_RISE_SEL}, {30'h0, RISE_3P4});
        check("drive", {31'h0, MII_DRIVE_HIGH}, 32'h0);
        print_verdict();
    end
endmodule
